// File: logic/vic_arbiter.sv
`default_nettype none
`include "vic_defs.svh"

module vic_arbiter
  import vic_pkg::*;
(
  input wire logic [`VIC_NUM_SRC-1:0] pending_i,
  input wire vic_cfg_t cfg_i,
  output vic_grant_t grant_o
);

  logic [`VIC_NUM_SRC-1:0] live;
  logic [`VIC_NUM_SRC-1:0] hi_req;
  logic [`VIC_NUM_SRC-1:0] lo_req;
  logic [`VIC_NUM_SRC:0] hi_seen;
  logic [`VIC_NUM_SRC:0] lo_seen;
  logic [`VIC_NUM_SRC-1:0] hi_first;
  logic [`VIC_NUM_SRC-1:0] lo_first;

  // Every source is gated by its own enable, read-only flags included
  assign live = pending_i & cfg_i.enable & `VIC_VALID_MASK & {`VIC_NUM_SRC{cfg_i.global_en}};
  assign hi_req = live & cfg_i.high;
  assign lo_req = live & ~cfg_i.high;
  assign hi_seen[0] = 1'b0;
  assign lo_seen[0] = 1'b0;

  genvar g;
  generate
    for (g = 0; g < `VIC_NUM_SRC; g = g + 1) begin : g_chain
      assign hi_first[g] = hi_req[g] & ~hi_seen[g];
      assign lo_first[g] = lo_req[g] & ~lo_seen[g];
      assign hi_seen[g+1] = hi_seen[g] | hi_req[g];
      assign lo_seen[g+1] = lo_seen[g] | lo_req[g];
    end
  endgenerate

  always_comb begin
    logic [`VIC_NUM_SRC-1:0] pick;
    pick = (|hi_req) ? hi_first : lo_first;
    grant_o.valid = |live;
    grant_o.high = |hi_req;
    grant_o.idx = '0;
    for (int i = 0; i < `VIC_NUM_SRC; i++) begin
      if (pick[i]) begin
        grant_o.idx = `VIC_IDX_W'(i);
      end
    end
  end

endmodule : vic_arbiter

`default_nettype wire

// File: logic/vic_defs.svh
// How it works
// - Sample and decode pending flags every clock
// - Best response seven clocks, call five
// - After return, one instruction before call
// - Worst response nineteen clocks, divide eight
// - Equal or higher routine defers new requests
// - Fixed vectors 0x0003 to 0x00AB, fixed order
// - Pin and timer flags cleared on vectoring
// - Orders 0-6 primary, 7 onward extended
// - Enable gates read-only flag sources too
// - Indirect flags accepted like direct flags
// - High preempts low, nothing preempts high
// - Global enable zero blocks every request
// - Same level: lowest order number wins
// - Flag still set after return re-enters
`ifndef VIC_DEFS_SVH
`define VIC_DEFS_SVH

`define VIC_NUM_SRC 22
`define VIC_IDX_W 5
`define VIC_VEC_W 16
`define VIC_VEC_BASE 16'h0003
`define VIC_VEC_STEP_SHIFT 3
`define VIC_VALID_MASK 22'h3bdfff
`define VIC_HWCLR_MASK 22'h00000f
`define VIC_PRI_BITS 7
`define VIC_EXT1_POS 7
`define VIC_EXT2_POS 15
`define VIC_GLOBAL_BIT 7
`define VIC_DETECT_CYC 1
`define VIC_CALL_CYC 5
`define VIC_RETURN_CYC 5
`define VIC_DIVIDE_CYC 8
`define VIC_BEST_CYC 7
`define VIC_WORST_CYC 19

`endif

// File: logic/vic_pkg.sv
`default_nettype none
`include "vic_defs.svh"

package vic_pkg;

  typedef enum logic [1:0] {
    VIC_IDLE = 2'b00,
    VIC_REQUEST = 2'b01,
    VIC_HOLDOFF = 2'b10
  } vic_state_t;

  typedef struct packed {
    logic global_en;
    logic [`VIC_NUM_SRC-1:0] enable;
    logic [`VIC_NUM_SRC-1:0] high;
  } vic_cfg_t;

  typedef struct packed {
    logic valid;
    logic high;
    logic [`VIC_IDX_W-1:0] idx;
  } vic_grant_t;

endpackage : vic_pkg

`default_nettype wire

// File: logic/vic_service.sv
`default_nettype none
`include "vic_defs.svh"

module vic_service
  import vic_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic push_i,
  input wire logic push_high_i,
  input wire logic pop_i,
  output logic act_low_o,
  output logic act_high_o
);

  logic act_low_reg;
  logic act_low_next;
  logic act_high_reg;
  logic act_high_next;

  // A return ends the innermost routine: high first, then low
  always_comb begin
    act_low_next = act_low_reg;
    act_high_next = act_high_reg;
    if (pop_i) begin
      if (act_high_reg) begin
        act_high_next = 1'b0;
      end else begin
        act_low_next = 1'b0;
      end
    end else if (push_i) begin
      if (push_high_i) begin
        act_high_next = 1'b1;
      end else begin
        act_low_next = 1'b1;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      act_low_reg <= 1'b0;
      act_high_reg <= 1'b0;
    end else begin
      act_low_reg <= act_low_next;
      act_high_reg <= act_high_next;
    end
  end

  assign act_low_o = act_low_reg;
  assign act_high_o = act_high_reg;

endmodule : vic_service

`default_nettype wire

// File: logic/vic_top.sv
`default_nettype none
`include "vic_defs.svh"

module vic_top
  import vic_pkg::*;
(
  input wire logic SYS_CLK_I,
  input wire logic RESET_I,
  // Pending flags from peripherals, direct and indirect spaces alike
  input wire logic [`VIC_NUM_SRC-1:0] PENDING_I,
  input wire logic [7:0] IE_REG_I,
  input wire logic [`VIC_PRI_BITS-1:0] PRIMARY_PRIORITY_REG_I,
  input wire logic [7:0] EXTENDED_ENABLE_ONE_I,
  input wire logic [7:0] EXTENDED_PRIORITY_ONE_I,
  input wire logic [6:0] EXTENDED_ENABLE_TWO_I,
  input wire logic [6:0] EXTENDED_PRIORITY_TWO_I,
  input wire logic INSTR_DONE_I,
  input wire logic RETURN_DONE_I,
  input wire logic CALL_ACK_I,
  output logic IRQ_REQ_O,
  output logic [`VIC_VEC_W-1:0] IRQ_VECTOR_O,
  output logic [`VIC_NUM_SRC-1:0] HW_CLEAR_O,
  output logic ACTIVE_LOW_O,
  output logic ACTIVE_HIGH_O
);

  ////////////////////////////////////////////////////////////////////////////
  // Configuration and decode

  vic_cfg_t cfg;
  vic_grant_t grant;
  logic act_low;
  logic act_high;
  logic allowed;
  logic push;
  logic [`VIC_IDX_W-1:0] idx_reg;
  logic [`VIC_IDX_W-1:0] idx_next;

  // Orders 0-6 in the primary pair, 7-14 and 15-21 in the extended pairs
  always_comb begin
    cfg.global_en = IE_REG_I[`VIC_GLOBAL_BIT];
    cfg.enable = {EXTENDED_ENABLE_TWO_I, EXTENDED_ENABLE_ONE_I,
                  IE_REG_I[`VIC_PRI_BITS-1:0]};
    cfg.high = {EXTENDED_PRIORITY_TWO_I, EXTENDED_PRIORITY_ONE_I,
                PRIMARY_PRIORITY_REG_I};
  end

  // Combinational decode of the live inputs, every clock
  vic_arbiter u_arbiter (
    .pending_i(PENDING_I),
    .cfg_i(cfg),
    .grant_o(grant)
  );

  // High may interrupt low; nothing interrupts high; equal level waits
  assign allowed = grant.valid && !act_high && (!act_low || grant.high);

  vic_service u_service (
    .clk_i(SYS_CLK_I),
    .rst_i(RESET_I),
    .push_i(push),
    .push_high_i(cfg.high[idx_reg]),
    .pop_i(RETURN_DONE_I),
    .act_low_o(act_low),
    .act_high_o(act_high)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Request sequencer

  vic_state_t state_reg;
  vic_state_t state_next;
  logic req_reg;
  logic req_next;
  logic [`VIC_VEC_W-1:0] vec_reg;
  logic [`VIC_VEC_W-1:0] vec_next;
  logic [`VIC_NUM_SRC-1:0] clr_reg;
  logic [`VIC_NUM_SRC-1:0] clr_next;
  logic [`VIC_VEC_W-1:0] grant_vec;

  // Eight-byte spacing above the first source vector
  assign grant_vec = `VIC_VEC_BASE +
                     (`VIC_VEC_W'(grant.idx) << `VIC_VEC_STEP_SHIFT);
  assign push = req_reg && CALL_ACK_I;

  always_comb begin
    state_next = state_reg;
    req_next = 1'b0;
    idx_next = idx_reg;
    vec_next = vec_reg;
    clr_next = '0;
    if (push) begin
      // Only the pin and basic timer flags are wiped here
      clr_next = (`VIC_NUM_SRC'(1) << idx_reg) & `VIC_HWCLR_MASK;
    end
    case (state_reg)
      VIC_IDLE: begin
        if (RETURN_DONE_I) begin
          state_next = VIC_HOLDOFF;
        end else if (allowed && !push) begin
          state_next = VIC_REQUEST;
          req_next = 1'b1;
          idx_next = grant.idx;
          vec_next = grant_vec;
        end
      end
      VIC_REQUEST: begin
        if (RETURN_DONE_I) begin
          state_next = VIC_HOLDOFF;
        end else if (push) begin
          state_next = VIC_IDLE;
        end else if (allowed) begin
          req_next = 1'b1;
          idx_next = grant.idx;
          vec_next = grant_vec;
        end else begin
          state_next = VIC_IDLE;
        end
      end
      VIC_HOLDOFF: begin
        // One instruction must complete after the return
        if (RETURN_DONE_I) begin
          state_next = VIC_HOLDOFF;
        end else if (INSTR_DONE_I) begin
          if (allowed) begin
            state_next = VIC_REQUEST;
            req_next = 1'b1;
            idx_next = grant.idx;
            vec_next = grant_vec;
          end else begin
            state_next = VIC_IDLE;
          end
        end
      end
      default: begin
        state_next = VIC_IDLE;
      end
    endcase
  end

  always_ff @(posedge SYS_CLK_I) begin
    if (RESET_I) begin
      state_reg <= VIC_IDLE;
      req_reg <= 1'b0;
      idx_reg <= '0;
      vec_reg <= '0;
      clr_reg <= '0;
    end else begin
      state_reg <= state_next;
      req_reg <= req_next;
      idx_reg <= idx_next;
      vec_reg <= vec_next;
      clr_reg <= clr_next;
    end
  end

  assign IRQ_REQ_O = req_reg;
  assign IRQ_VECTOR_O = vec_reg;
  assign HW_CLEAR_O = clr_reg;
  assign ACTIVE_LOW_O = act_low;
  assign ACTIVE_HIGH_O = act_high;

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  default clocking cb @(posedge SYS_CLK_I);
  endclocking
  default disable iff (RESET_I);

  sequence s_return_seen;
    RETURN_DONE_I ##1 (!INSTR_DONE_I && !RETURN_DONE_I);
  endsequence

  sequence s_holdoff_end;
    state_reg == VIC_HOLDOFF && INSTR_DONE_I && !RETURN_DONE_I && allowed;
  endsequence

  sequence s_ack_taken;
    push && !RETURN_DONE_I;
  endsequence

  sequence s_high_return;
    RETURN_DONE_I && ACTIVE_HIGH_O;
  endsequence

  a_detect_one_clock: assert property (
    (state_reg == VIC_IDLE && allowed && !RETURN_DONE_I && !push) |=> IRQ_REQ_O)
    else $error("request not raised one clock after detection");

  a_return_holdoff: assert property (
    s_return_seen |-> !IRQ_REQ_O ##1 (state_reg == VIC_HOLDOFF))
    else $error("request issued before the instruction after return");

  a_holdoff_release: assert property (
    s_holdoff_end |=> IRQ_REQ_O && IRQ_VECTOR_O == $past(grant_vec))
    else $error("pending flag not re-requested after return");

  a_hw_clear_pulse: assert property (
    (push && idx_reg < 5'h04) |=> HW_CLEAR_O == (22'h000001 << $past(idx_reg)) ##1
      HW_CLEAR_O == 22'h000000)
    else $error("hardware flag clear missing or not a single pulse");

  a_sw_flags_kept: assert property (
    (push && idx_reg >= 5'h04) |=> HW_CLEAR_O == 22'h000000)
    else $error("software-cleared flag was cleared by hardware");

  a_vector_map: assert property (
    IRQ_REQ_O |-> IRQ_VECTOR_O == 16'h0003 + {8'h00, idx_reg, 3'h0} &&
      idx_reg != 5'h0d && idx_reg != 5'h12)
    else $error("vector does not match source order");

  a_global_gate: assert property (
    !IE_REG_I[`VIC_GLOBAL_BIT] |=> !IRQ_REQ_O)
    else $error("request raised with global enable low");

  a_high_not_preempted: assert property (
    ACTIVE_HIGH_O |-> !IRQ_REQ_O)
    else $error("request raised during a high level routine");

  a_low_defers_equal: assert property (
    (ACTIVE_LOW_O && IRQ_REQ_O) |-> cfg.high[idx_reg] || $past(RETURN_DONE_I, 2))
    else $error("low level request raised during a low level routine");

  a_ack_records_level: assert property (
    (push && !RETURN_DONE_I && cfg.high[idx_reg]) |=> ACTIVE_HIGH_O && !IRQ_REQ_O)
    else $error("active high level not recorded on acknowledge");

  // Request and vector shape
  a_req_in_request: assert property (
    IRQ_REQ_O |-> state_reg == VIC_REQUEST)
    else $error("request standing outside the request state");

  a_idle_quiet: assert property (
    state_reg == VIC_IDLE |-> !IRQ_REQ_O)
    else $error("request standing while idle");

  a_grant_follows: assert property (
    (state_reg == VIC_REQUEST && allowed && !push && !RETURN_DONE_I) |=>
      IRQ_VECTOR_O == $past(grant_vec))
    else $error("standing request did not follow the current winner");

  a_withdraw_req: assert property (
    (IRQ_REQ_O && !allowed && !push && !RETURN_DONE_I) |=> !IRQ_REQ_O)
    else $error("request kept after it lost eligibility");

  a_vector_range: assert property (
    IRQ_REQ_O |-> IRQ_VECTOR_O >= 16'h0003 && IRQ_VECTOR_O <= 16'h00ab)
    else $error("vector outside the source table");

  a_vector_low_bits: assert property (
    IRQ_REQ_O |-> IRQ_VECTOR_O[2:0] == 3'h3)
    else $error("vector not on the eight byte grid");

  // Acknowledge and clear pulse
  a_ack_drops_req: assert property (
    s_ack_taken |=> !IRQ_REQ_O)
    else $error("request still standing after acknowledge");

  a_ack_low_level: assert property (
    (push && !RETURN_DONE_I && !cfg.high[idx_reg]) |=> ACTIVE_LOW_O)
    else $error("active low level not recorded on acknowledge");

  a_clear_pins_only: assert property (
    HW_CLEAR_O[21:4] == 18'h00000)
    else $error("clear pulse on a software-cleared source");

  a_clear_one_hot: assert property (
    $onehot0(HW_CLEAR_O))
    else $error("more than one flag cleared at once");

  a_clear_after_ack: assert property (
    (HW_CLEAR_O != 22'h000000) |-> $past(push))
    else $error("clear pulse without an acknowledge");

  a_high_needs_ack: assert property (
    $rose(ACTIVE_HIGH_O) |-> $past(push))
    else $error("high level entered without an acknowledge");

  a_low_needs_ack: assert property (
    $rose(ACTIVE_LOW_O) |-> $past(push))
    else $error("low level entered without an acknowledge");

  // Return path
  a_return_withdraws: assert property (
    RETURN_DONE_I |=> !IRQ_REQ_O)
    else $error("request kept across a return");

  a_holdoff_quiet: assert property (
    state_reg == VIC_HOLDOFF |-> !IRQ_REQ_O)
    else $error("request standing during holdoff");

  a_holdoff_waits: assert property (
    (state_reg == VIC_HOLDOFF && !INSTR_DONE_I) |=> !IRQ_REQ_O)
    else $error("request raised before the instruction after return");

  a_high_return_pop: assert property (
    s_high_return |=> !ACTIVE_HIGH_O && ACTIVE_LOW_O == $past(ACTIVE_LOW_O))
    else $error("return from high level did not resume the low level");

  a_low_return_pop: assert property (
    (RETURN_DONE_I && !ACTIVE_HIGH_O) |=> !ACTIVE_LOW_O)
    else $error("return from low level left the level active");

endmodule : vic_top

`default_nettype wire

// File: sim/vic_core_model.sv
`default_nettype none
module vic_core_model (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic req_i,
  input wire logic [3:0] wait_i,
  output logic ack_o
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [3:0] cnt_reg;
  // Call begins once the request has stood wait_i+1 edges
  always @(posedge clk_i) begin
    if (rst_i || !req_i || ack_o) begin
      cnt_reg <= 4'h0;
      ack_o <= 1'b0;
    end else if (cnt_reg == wait_i) begin
      ack_o <= 1'b1;
    end else begin
      cnt_reg <= cnt_reg + 4'h1;
    end
  end
endmodule : vic_core_model
`default_nettype wire

// File: sim/vic_top_test.sv
`default_nettype none
module vic_top_test;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic ge = 1'b0;
  logic idone = 1'b0;
  logic rdone = 1'b0;
  logic ack, req, alo, ahi;
  logic [15:0] vec;
  logic [21:0] clr;
  logic [21:0] pend = 22'h0;
  logic [21:0] en = 22'h3fffff;
  logic [21:0] hi = 22'h0;
  logic [3:0] wt = 4'h0;
  int error_cnt = 0;
  int tests_run = 0;
  always #20 clk = ~clk;
  vic_top vic_top_i (
    .SYS_CLK_I(clk), .RESET_I(rst), .PENDING_I(pend), .IE_REG_I({ge, en[6:0]}),
    .PRIMARY_PRIORITY_REG_I(hi[6:0]), .EXTENDED_ENABLE_ONE_I(en[14:7]),
    .EXTENDED_PRIORITY_ONE_I(hi[14:7]), .EXTENDED_ENABLE_TWO_I(en[21:15]),
    .EXTENDED_PRIORITY_TWO_I(hi[21:15]), .INSTR_DONE_I(idone), .RETURN_DONE_I(rdone),
    .CALL_ACK_I(ack), .IRQ_REQ_O(req), .IRQ_VECTOR_O(vec), .HW_CLEAR_O(clr),
    .ACTIVE_LOW_O(alo), .ACTIVE_HIGH_O(ahi));
  vic_core_model vic_core_model_i (.clk_i(clk), .rst_i(rst), .req_i(req), .wait_i(wt),
    .ack_o(ack));
  ////////////////////////////////////////////////////////////////////////////////
  task automatic tick;
    @(posedge clk);
    #1;
  endtask : tick
  task automatic check(input string what, input logic [21:0] seen, input logic [21:0] exp);
    tests_run++;
    if (seen !== exp) begin
      error_cnt++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic end_of_test;
    $display("Checks %0d mismatches %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : end_of_test
  // Expects a standing request, lets the core take it, judges the outcome
  task automatic serve(input int n, input logic h, input logic [21:0] c);
    int k;
    k = 0;
    check("request", req, 22'h1);
    check("vector", vec, 22'h3 + 22'(8 * n));
    while (ack !== 1'b1 && k < 20) begin
      tick;
      k++;
    end
    tick;
    check("clear", clr, c);
    check("req after ack", req, 22'h0);
    check("high level", ahi, h);
  endtask : serve
  task automatic ret(input logic l, input logic h);
    rdone = 1'b1;
    tick;
    rdone = 1'b0;
    check("low after return", alo, l);
    check("high after return", ahi, h);
    check("holdoff", req, 22'h0);
    tick;
    check("holdoff wait", req, 22'h0);
    idone = 1'b1;
    tick;
    idone = 1'b0;
  endtask : ret
  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_orders;
    for (int n = 0; n < 22; n++) begin
      pend = 22'h1 << n;
      hi = n[0] ? 22'h3fffff : 22'h0;
      tick;
      if (n == 13 || n == 18) begin
        check("reserved", req, 22'h0);
      end else begin
        serve(n, n[0], n < 4 ? 22'h1 << n : 22'h0);
      end
      pend = 22'h0;
      if (n != 13 && n != 18) begin
        ret(1'b0, 1'b0);
      end
    end
    $display("Test orders done");
  endtask : t_orders
  task automatic t_global;
    hi = 22'h0;
    en = 22'h3f7fff;
    pend = 22'h8000;
    repeat (2) tick;
    check("enable off", req, 22'h0);
    en = 22'h3fffff;
    pend = 22'h10;
    ge = 1'b0;
    repeat (3) tick;
    check("global off", req, 22'h0);
    ge = 1'b1;
    tick;
    serve(4, 1'b0, 22'h0);
    ret(1'b0, 1'b0);
    serve(4, 1'b0, 22'h0);
    pend = 22'h0;
    ret(1'b0, 1'b0);
    $display("Test global and reentry done");
  endtask : t_global
  task automatic t_preempt;
    pend = 22'h10;
    tick;
    serve(4, 1'b0, 22'h0);
    check("low active", alo, 22'h1);
    pend = 22'h30;
    repeat (2) tick;
    check("equal deferred", req, 22'h0);
    hi = 22'h400;
    pend = 22'h434;
    tick;
    serve(10, 1'b1, 22'h0);
    check("low kept", alo, 22'h1);
    hi = 22'h404;
    repeat (2) tick;
    check("high not preempted", req, 22'h0);
    pend = 22'h0;
    ret(1'b1, 1'b0);
    ret(1'b0, 1'b0);
    $display("Test preemption done");
  endtask : t_preempt
  task automatic t_arb;
    wt = 4'h6;
    hi = 22'h0;
    pend = 22'h100280;
    tick;
    check("lowest order", vec, 22'h3b);
    hi = 22'h100000;
    tick;
    check("high wins", vec, 22'ha3);
    serve(20, 1'b1, 22'h0);
    pend = 22'h0;
    ret(1'b0, 1'b0);
    wt = 4'h0;
    $display("Test arbitration done");
  endtask : t_arb
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (12) tick;
    rst = 1'b0;
    ge = 1'b1;
    tick;
    t_orders;
    t_global;
    t_preempt;
    t_arb;
    end_of_test;
  end
  initial begin
    #100000;
    error_cnt++;
    end_of_test;
  end
endmodule : vic_top_test
`default_nettype wire
